// ==== src/pcc_params.svh ====
// register map constants for the pcie capability configuration bank
//////////////////////////////////////////////////////////////////////////////
// How it works
// - payload size field writable, resets 000
// - read request size writable, resets 2h
// - extended tag enable writable, resets zero
// - no-snoop enable reads zero, ignores writes
// - phantom and aux power enables read zero
// - pending bit mirrors outstanding transaction state
// - max link speed reads 0001
// - max link width reads 000100, x4
// - aspm support reads 11
// - aspm control writable, resets 00
// - link disable, retrain locked in forward mode
// - completion boundary bit reads zero
// - negotiated speed and width, reset 2.5G x4
// - slot hot-plug bits only strapped reverse mode
// - four slot event enables writable, reset zero
// - command and hot-plug interrupt enables writable
//////////////////////////////////////////////////////////////////////////////
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// decode width and register byte offsets
`define PCC_ADDR_W        8
`define PCC_OFF_DEVICE    8'hb8
`define PCC_OFF_LINK_CAP  8'hbc
`define PCC_OFF_LINK      8'hc0
`define PCC_OFF_SLOT_CAP  8'hc4
`define PCC_OFF_SLOT      8'hc8
`define PCC_OFF_PHY0      8'hcc
`define PCC_OFF_PHY1      8'hd0
`define PCC_OFF_IRQ_STS   8'he0
`define PCC_OFF_IRQ_EN    8'he4
`define PCC_OFF_IRQ_CLR   8'he8

// ahb codes
`define PCC_HSIZE_WORD    3'h2
`define PCC_HRESP_OKAY    1'h0

// device control: writable bits and reset
`define PCC_DCTL_WMASK    16'hf1ef
`define PCC_DCTL_RESET    16'h2000
`define PCC_DCTL_RO_ZERO  16'h0e10

// device status fields
`define PCC_NUM_ERR       4
`define PCC_DSTS_ERR_LSB  16
`define PCC_DSTS_AUX      1'h1

// link capability word: port, reserved, l1 exit, l0s exit, aspm, width, speed
`define PCC_LCAP_VALUE    {8'h00, 6'h00, 3'h0, 3'h3, 2'h3, 6'h04, 4'h1}

// link control: always writable bits and mode-locked bits
`define PCC_LCTL_WMASK    16'h00c3
`define PCC_LCTL_MODE     16'h0030
`define PCC_LCTL_RESET    16'h0000

// link status reset values and fixed bits
`define PCC_LSPD_RESET    4'h1
`define PCC_LWID_RESET    6'h04
`define PCC_LSTS_SLOTCLK  1'h1

// slot capability bits that follow the hot-plug strap
`define PCC_SCAP_HP_MASK  32'h0000005d

// slot control
`define PCC_SCTL_WMASK    16'h07ff
`define PCC_SCTL_RESET    16'h0000
`define PCC_SSTS_W        7

// phy tuning registers
`define PCC_PHY0_WMASK    32'hffff1fff
`define PCC_PHY0_RESET    32'h04001060
`define PCC_PHY1_WMASK    32'hffff03ff
`define PCC_PHY1_RESET    32'h00000000

`endif

// ==== src/pcc_pkg.sv ====
// types shared by the pcie capability register bank
package pcc_pkg;
    typedef enum logic {
        PCC_BUS_IDLE,
        PCC_BUS_WAIT
    } pcc_bus_t;
endpackage

// ==== src/pcc_sync.sv ====
// two flip-flop level synchroniser for pin inputs
`timescale 1ns/1ps
module pcc_sync
    import pcc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ==== src/pcc_regs.sv ====
// pcie capability configuration register bank behind an ahb-lite slave
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_regs
    import pcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        forward_pin,
    input  wire logic        hotplug_pin,
    input  wire logic        txn_pending,
    input  wire logic [3:0]  err_event,
    input  wire logic [3:0]  link_speed_in,
    input  wire logic [5:0]  link_width_in,
    input  wire logic [6:0]  slot_state_in,
    output logic             irq,
    output logic      [15:0] device_control,
    output logic      [15:0] link_control,
    output logic      [15:0] slot_control,
    output logic      [31:0] phy_tuning_config_0,
    output logic      [31:0] phy_tuning_config_1
);
    //////////////////////////////////////////////////////////////////////////
    // strap inputs
    logic [1:0]              strap_sync;
    logic                    forward_mode;
    logic                    hotplug_en;

    pcc_sync #(
        .WIDTH (2)
    ) u_strap_sync (
        .clk (clk),
        .rst (rst),
        .d   ({forward_pin, hotplug_pin}),
        .q   (strap_sync)
    );

    // hot-plug only counts in reverse bridge mode
    assign forward_mode = strap_sync[1];
    assign hotplug_en   = strap_sync[0] & ~strap_sync[1];

    //////////////////////////////////////////////////////////////////////////
    // ahb-lite transfer tracking
    pcc_bus_t                bus_state;
    logic [`PCC_ADDR_W-1:0]  acc_addr;
    logic                    acc_write;
    logic                    acc_word;
    logic                    acc_map;
    logic                    accept;
    logic                    wr_en;
    logic                    rd_en;

    assign accept = hsel && hready && htrans[1] && (bus_state == PCC_BUS_IDLE);
    assign wr_en  = (bus_state == PCC_BUS_WAIT) && acc_write && acc_word && acc_map;
    assign rd_en  = (bus_state == PCC_BUS_WAIT) && !acc_write;

    // one wait state per transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_state <= PCC_BUS_IDLE;
        end else begin
            unique case (bus_state)
                PCC_BUS_IDLE: begin
                    if (accept) begin
                        bus_state <= PCC_BUS_WAIT;
                    end
                end
                PCC_BUS_WAIT: begin
                    bus_state <= PCC_BUS_IDLE;
                end
            endcase
        end
    end

    // address phase capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_addr  <= '0;
            acc_write <= 1'b0;
            acc_word  <= 1'b0;
            acc_map   <= 1'b0;
        end else if (accept) begin
            acc_addr  <= haddr[`PCC_ADDR_W-1:0];
            acc_write <= hwrite;
            acc_word  <= (hsize == `PCC_HSIZE_WORD);
            acc_map   <= (haddr[31:`PCC_ADDR_W] == '0);
        end
    end

    // ready low during the wait state, always okay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= `PCC_HRESP_OKAY;
        end else begin
            hreadyout <= !accept;
            hresp     <= `PCC_HRESP_OKAY;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // device control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            device_control <= `PCC_DCTL_RESET;
        end else if (wr_en && acc_addr == `PCC_OFF_DEVICE) begin
            // bits 11:9 and 4 stay zero
            device_control <= (hwdata[15:0] & `PCC_DCTL_WMASK);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // device status, event flags and interrupt status
    logic [`PCC_NUM_ERR-1:0] dev_err;
    logic [`PCC_NUM_ERR-1:0] irq_status;
    logic [`PCC_NUM_ERR-1:0] irq_enable;
    logic                    txn_pend;

    for (genvar i = 0; i < `PCC_NUM_ERR; i++) begin : g_err
        // set wins over a write-one clear
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                dev_err[i] <= 1'b0;
            end else if (err_event[i]) begin
                dev_err[i] <= 1'b1;
            end else if (wr_en && acc_addr == `PCC_OFF_DEVICE && hwdata[`PCC_DSTS_ERR_LSB + i]) begin
                dev_err[i] <= 1'b0;
            end
        end

        // sticky interrupt cause
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                irq_status[i] <= 1'b0;
            end else if (err_event[i]) begin
                irq_status[i] <= 1'b1;
            end else if (wr_en && acc_addr == `PCC_OFF_IRQ_CLR && hwdata[i]) begin
                irq_status[i] <= 1'b0;
            end
        end
    end

    // transaction pending mirror
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txn_pend <= 1'b0;
        end else begin
            txn_pend <= txn_pending;
        end
    end

    // interrupt enable and output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_enable <= '0;
            irq        <= 1'b0;
        end else begin
            if (wr_en && acc_addr == `PCC_OFF_IRQ_EN) begin
                irq_enable <= hwdata[`PCC_NUM_ERR-1:0];
            end
            irq <= |(irq_status & irq_enable);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // link control and status
    logic [3:0]              lnk_speed;
    logic [5:0]              lnk_width;
    logic [15:0]             link_wmask;

    // disable and retrain only writable in reverse mode
    assign link_wmask = forward_mode ? `PCC_LCTL_WMASK : (`PCC_LCTL_WMASK | `PCC_LCTL_MODE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_control <= `PCC_LCTL_RESET;
        end else if (wr_en && acc_addr == `PCC_OFF_LINK) begin
            // bit 3 has no writable path
            link_control <= (link_control & ~link_wmask) | (hwdata[15:0] & link_wmask);
        end
    end

    // negotiated values from the link layer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lnk_speed <= `PCC_LSPD_RESET;
            lnk_width <= `PCC_LWID_RESET;
        end else begin
            lnk_speed <= link_speed_in;
            lnk_width <= link_width_in;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // slot control, slot status and phy tuning
    logic [`PCC_SSTS_W-1:0]  slot_sts;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slot_control <= `PCC_SCTL_RESET;
        end else if (wr_en && acc_addr == `PCC_OFF_SLOT) begin
            slot_control <= hwdata[15:0] & `PCC_SCTL_WMASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slot_sts <= '0;
        end else begin
            slot_sts <= slot_state_in;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phy_tuning_config_0 <= `PCC_PHY0_RESET;
            phy_tuning_config_1 <= `PCC_PHY1_RESET;
        end else if (wr_en) begin
            if (acc_addr == `PCC_OFF_PHY0) begin
                phy_tuning_config_0 <= hwdata & `PCC_PHY0_WMASK;
            end
            if (acc_addr == `PCC_OFF_PHY1) begin
                phy_tuning_config_1 <= hwdata & `PCC_PHY1_WMASK;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read path
    logic [31:0]             rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (acc_addr)
            `PCC_OFF_DEVICE:   rd_mux = {10'h000, txn_pend, `PCC_DSTS_AUX, dev_err, device_control};
            `PCC_OFF_LINK_CAP: rd_mux = `PCC_LCAP_VALUE;
            `PCC_OFF_LINK:     rd_mux = {3'h0, `PCC_LSTS_SLOTCLK, 2'h0, lnk_width, lnk_speed, link_control};
            `PCC_OFF_SLOT_CAP: rd_mux = hotplug_en ? `PCC_SCAP_HP_MASK : 32'h00000000;
            `PCC_OFF_SLOT:     rd_mux = {9'h000, slot_sts, slot_control};
            `PCC_OFF_PHY0:     rd_mux = phy_tuning_config_0;
            `PCC_OFF_PHY1:     rd_mux = phy_tuning_config_1;
            `PCC_OFF_IRQ_STS:  rd_mux = {28'h0000000, irq_status};
            `PCC_OFF_IRQ_EN:   rd_mux = {28'h0000000, irq_enable};
            default:           rd_mux = '0;
        endcase
    end

    // unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= '0;
        end else if (rd_en) begin
            hrdata <= acc_map ? rd_mux : 32'h00000000;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    bus_wait_state_a: assert property (accept |=> !hreadyout ##1 hreadyout)
        else $error("transfer not answered after one wait state");

    payload_write_a: assert property (
        wr_en && acc_addr == `PCC_OFF_DEVICE |=> device_control[7:5] == $past(hwdata[7:5]))
        else $error("payload size not written");

    readreq_write_a: assert property (
        wr_en && acc_addr == `PCC_OFF_DEVICE |=> device_control[14:12] == $past(hwdata[14:12]) &&
            device_control[8] == $past(hwdata[8]))
        else $error("read request size or tag enable not written");

    devctl_ro_zero_a: assert property ((device_control & `PCC_DCTL_RO_ZERO) == 16'h0000)
        else $error("read-only device control bit set");

    pending_mirror_a: assert property (
        rd_en && acc_map && acc_addr == `PCC_OFF_DEVICE |=> hrdata[21] == $past(txn_pend))
        else $error("pending bit not reported");

    link_cap_read_a: assert property (
        rd_en && acc_map && acc_addr == `PCC_OFF_LINK_CAP |=> hrdata[11:0] == 12'hc41)
        else $error("link capability value wrong");

    link_lock_a: assert property (
        forward_mode && wr_en && acc_addr == `PCC_OFF_LINK |=> $stable(link_control[5:4]))
        else $error("link disable or retrain changed in forward mode");

    rcb_zero_a: assert property (link_control[3:2] == 2'h0)
        else $error("completion boundary bit set");

    slot_cap_read_a: assert property (
        rd_en && acc_map && acc_addr == `PCC_OFF_SLOT_CAP |=>
            hrdata == ($past(hotplug_en) ? `PCC_SCAP_HP_MASK : 32'h00000000))
        else $error("slot capability does not follow strap");

    slot_ctrl_write_a: assert property (
        wr_en && acc_addr == `PCC_OFF_SLOT |=> slot_control[5:0] == $past(hwdata[5:0]))
        else $error("slot control enables not written");

    err_set_wins_a: assert property (err_event[0] |=> dev_err[0] ##1 (dev_err[0] || !$past(wr_en)))
        else $error("error event lost");

    irq_follow_a: assert property (irq_status[1] && irq_enable[1] |=> irq)
        else $error("enabled interrupt not raised");

    err_all_set_a: assert property (err_event != 4'h0 |=> (dev_err & $past(err_event)) == $past(err_event))
        else $error("device status error bit not set");

    irq_sts_set_a: assert property (err_event != 4'h0 |=> (irq_status & $past(err_event)) == $past(err_event))
        else $error("interrupt status bit not set");

    err_w1c_a: assert property (
        wr_en && acc_addr == `PCC_OFF_DEVICE && err_event == 4'h0 |=>
            (dev_err & $past(hwdata[19:16])) == 4'h0)
        else $error("device status error bit not cleared");

    aspm_write_a: assert property (
        wr_en && acc_addr == `PCC_OFF_LINK |=> link_control[1:0] == $past(hwdata[1:0]))
        else $error("aspm control not written");

    slot_irq_en_a: assert property (
        wr_en && acc_addr == `PCC_OFF_SLOT |=> slot_control[5:4] == $past(hwdata[5:4]))
        else $error("slot interrupt enables not written");

    irq_level_a: assert property (irq == $past(|(irq_status & irq_enable)))
        else $error("interrupt output does not follow enabled status");

    write_cov: cover property (accept && hwrite ##2 hreadyout);
    read_cov: cover property (accept && !hwrite ##2 hreadyout);
    err_clear_cov: cover property (dev_err[2] ##1 !dev_err[2]);
    irq_cov: cover property (!irq ##1 irq);
    set_clear_cov: cover property (err_event[0] && wr_en && acc_addr == `PCC_OFF_DEVICE);
endmodule

// ==== tb/pcc_link_model.sv ====
// far-side model driving link, slot and transaction-layer state
`timescale 1ns/1ps
module pcc_link_model (
    input  wire logic       clk,
    output logic            txn_pending,
    output logic      [3:0] err_event,
    output logic      [3:0] link_speed_in,
    output logic      [5:0] link_width_in,
    output logic      [6:0] slot_state_in
);
    // idle link trained at 2.5g x4, nothing outstanding
    initial begin
        txn_pending = 1'b0;
        err_event = 4'h0;
        link_speed_in = 4'h1;
        link_width_in = 6'h04;
        slot_state_in = 7'h00;
    end

    // one-cycle error pulse as the link layer reports it
    task automatic pulse_error(input int i);
        @(posedge clk);
        err_event <= 4'h1 << i;
        @(posedge clk);
        err_event <= 4'h0;
    endtask

    // level while a request is outstanding
    task automatic set_pending(input logic v);
        @(posedge clk);
        txn_pending <= v;
    endtask

    // renegotiated width and new slot state
    task automatic set_state(input logic [5:0] w, input logic [6:0] s);
        @(posedge clk);
        link_width_in <= w;
        slot_state_in <= s;
    endtask
endmodule

// ==== tb/tb_top.sv ====
// register bank testbench with ahb-lite master tasks
`timescale 1ns/1ps
module tb_top
    import pcc_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        forward_pin;
    logic        hotplug_pin;
    logic        txn_pending;
    logic [3:0]  err_event;
    logic [3:0]  link_speed_in;
    logic [5:0]  link_width_in;
    logic [6:0]  slot_state_in;
    logic        irq;
    logic [15:0] device_control;
    logic [15:0] link_control;
    logic [15:0] slot_control;
    logic [31:0] phy_tuning_config_0;
    logic [31:0] phy_tuning_config_1;
    int          bad_count = 0;
    int          tests_run = 0;

    assign hready = hreadyout;

    pcc_regs pcc_regs_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .forward_pin(forward_pin), .hotplug_pin(hotplug_pin),
        .txn_pending(txn_pending), .err_event(err_event), .link_speed_in(link_speed_in),
        .link_width_in(link_width_in), .slot_state_in(slot_state_in), .irq(irq),
        .device_control(device_control), .link_control(link_control), .slot_control(slot_control),
        .phy_tuning_config_0(phy_tuning_config_0), .phy_tuning_config_1(phy_tuning_config_1));

    pcc_link_model pcc_link_model_i (.clk(clk), .txn_pending(txn_pending), .err_event(err_event),
        .link_speed_in(link_speed_in), .link_width_in(link_width_in), .slot_state_in(slot_state_in));

    // 10 mhz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    //////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one single ahb-lite word transfer, held until hready
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        logic late;
        n = 0;
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
        late = (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
        q = hrdata;
        if (late || hready !== 1'b1) begin
            bad_count++;
            $display("MISMATCH t=%0t bus transfer timed out", $time);
            stop_test();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    //////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        forward_pin = 1'b0;
        hotplug_pin = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        cyc(4);
        // reset values
        rd(32'hb8, 32'h00102000);
        rd(32'hbc, 32'h00003c41);
        rd(32'hc0, 32'h10410000);
        rd(32'hc4, 32'h0000005d);
        rd(32'hc8, 32'h00000000);
        rd(32'hcc, 32'h04001060);
        rd(32'hd0, 32'h00000000);
        chk({31'h0, hresp}, 32'h0);
        $display("test reset done");
        // writable and read-only bits
        wr(32'hb8, 32'hffffffff);
        rd(32'hb8, 32'h0010f1ef);
        wr(32'hb8, 32'h000050a0);
        rd(32'hb8, 32'h001050a0);
        chk({16'h0, device_control}, 32'h50a0);
        wr(32'hc0, 32'hffffffff);
        rd(32'hc0, 32'h104100f3);
        chk({16'h0, link_control}, 32'h000000f3);
        wr(32'hc8, 32'hffffffff);
        rd(32'hc8, 32'h000007ff);
        chk({16'h0, slot_control}, 32'h000007ff);
        wr(32'hcc, 32'hffffffff);
        rd(32'hcc, 32'hffff1fff);
        wr(32'hd0, 32'hffffffff);
        rd(32'hd0, 32'hffff03ff);
        chk(phy_tuning_config_0, 32'hffff1fff);
        chk(phy_tuning_config_1, 32'hffff03ff);
        wr(32'hd4, 32'hffffffff);
        rd(32'hd4, 32'h00000000);
        rd(32'h100, 32'h00000000);
        $display("test access done");
        // forward mode locks link bits and drops hot-plug
        forward_pin <= 1'b1;
        cyc(4);
        wr(32'hc0, 32'h00000000);
        rd(32'hc0, 32'h10410030);
        chk({16'h0, link_control}, 32'h00000030);
        rd(32'hc4, 32'h00000000);
        forward_pin <= 1'b0;
        hotplug_pin <= 1'b0;
        cyc(4);
        rd(32'hc4, 32'h00000000);
        $display("test straps done");
        // link and transaction-layer state
        pcc_link_model_i.set_pending(1'b1);
        pcc_link_model_i.set_state(6'h01, 7'h55);
        cyc(2);
        rd(32'hb8, 32'h003050a0);
        rd(32'hc0, 32'h10110030);
        rd(32'hc8, 32'h005507ff);
        pcc_link_model_i.set_pending(1'b0);
        cyc(2);
        rd(32'hb8, 32'h001050a0);
        $display("test status done");
        // each error kind: masked, enabled, cleared
        for (int i = 0; i < 4; i++) begin
            pcc_link_model_i.pulse_error(i);
            cyc(2);
            chk({31'h0, irq}, 32'h0);
            rd(32'he0, 32'h1 << i);
            rd(32'hb8, 32'h001050a0 | (32'h1 << (16 + i)));
            wr(32'he4, 32'h1 << i);
            cyc(2);
            chk({31'h0, irq}, 32'h1);
            wr(32'he8, 32'h1 << i);
            cyc(2);
            chk({31'h0, irq}, 32'h0);
            rd(32'he0, 32'h0);
            wr(32'hb8, 32'h000050a0 | (32'h1 << (16 + i)));
            rd(32'hb8, 32'h001050a0);
        end
        // error pulse in the same cycle as its clear: set wins
        fork
            wr(32'hb8, 32'h000150a0);
            begin
                cyc(1);
                pcc_link_model_i.pulse_error(0);
            end
        join
        rd(32'hb8, 32'h001150a0);
        fork
            wr(32'he8, 32'h00000001);
            begin
                cyc(1);
                pcc_link_model_i.pulse_error(0);
            end
        join
        rd(32'he0, 32'h00000001);
        wr(32'hb8, 32'h000150a0);
        wr(32'he8, 32'h00000001);
        rd(32'hb8, 32'h001050a0);
        rd(32'he0, 32'h00000000);
        $display("test events done");
        // second reset in mid-run returns reset values
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(4);
        chk({16'h0, link_control}, 32'h00000000);
        chk({16'h0, slot_control}, 32'h00000000);
        chk(phy_tuning_config_0, 32'h04001060);
        chk(phy_tuning_config_1, 32'h00000000);
        chk({31'h0, irq}, 32'h0);
        rd(32'hb8, 32'h00102000);
        rd(32'he0, 32'h00000000);
        rd(32'he4, 32'h00000000);
        $display("test reset again done");
        stop_test();
    end
endmodule
